// File: ccr_pkg.sv
// Register map, field layout and reset values of the channel calibration registers.
`default_nettype none
package ccr_pkg;
  // ********************************************************
  // Sizes.
  // ********************************************************
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned LO_W     = 8;
  localparam int unsigned WORD_W   = 24;
  localparam int unsigned SLOT_W   = 3;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned STRB_W   = 4;
  localparam int unsigned ADDR_LSB = 2;
  // ********************************************************
  // Register indices; the byte address is four times the index.
  // ********************************************************
  localparam logic [7:0] IDX_CH1_OFFSET_HIGH = 8'h0f;
  localparam logic [7:0] IDX_CH1_OFFSET_LOW  = 8'h10;
  localparam logic [7:0] IDX_CH1_GAIN_HIGH   = 8'h11;
  localparam logic [7:0] IDX_CH1_GAIN_LOW    = 8'h12;
  localparam logic [7:0] IDX_CH2_CONFIG      = 8'h13;
  localparam logic [7:0] IDX_CH2_OFFSET_HIGH = 8'h14;
  localparam logic [7:0] IDX_FIRST           = IDX_CH1_OFFSET_HIGH;
  localparam logic [7:0] IDX_LAST            = IDX_CH2_OFFSET_HIGH;
  // ********************************************************
  // Storage slots, reset values and writable bits.
  // ********************************************************
  localparam int unsigned SLOT_CH1_OFFSET_HIGH = 0;
  localparam int unsigned SLOT_CH1_OFFSET_LOW  = 1;
  localparam int unsigned SLOT_CH1_GAIN_HIGH   = 2;
  localparam int unsigned SLOT_CH1_GAIN_LOW    = 3;
  localparam int unsigned SLOT_CH2_CONFIG      = 4;
  localparam int unsigned SLOT_CH2_OFFSET_HIGH = 5;
  localparam logic [REG_W-1:0] RST_ZERO      = 16'h0000;
  localparam logic [REG_W-1:0] RST_GAIN_HIGH = 16'h8000;
  localparam logic [REG_W-1:0] MASK_FULL     = 16'hffff;
  localparam logic [REG_W-1:0] MASK_LOW_REG  = 16'hff00;
  localparam logic [REG_W-1:0] MASK_CONFIG   = 16'hffc7;
  localparam logic [REG_W-1:0] RESET_VALS [NUM_REGS] = '{
    RST_ZERO, RST_ZERO, RST_GAIN_HIGH, RST_ZERO, RST_ZERO, RST_ZERO};
  localparam logic [REG_W-1:0] WRITE_MASKS [NUM_REGS] = '{
    MASK_FULL, MASK_LOW_REG, MASK_FULL, MASK_LOW_REG, MASK_CONFIG, MASK_FULL};
  // ********************************************************
  // Fields.
  // ********************************************************
  localparam int unsigned LO_BYTE_LSB   = 8;
  localparam int unsigned RSVD_LSB      = 0;
  localparam int unsigned RSVD_W        = 8;
  localparam int unsigned CFG_PHASE_LSB = 6;
  localparam int unsigned PHASE_W       = 10;
  localparam int unsigned CFG_RSVD_LSB  = 3;
  localparam int unsigned CFG_RSVD_W    = 3;
  localparam int unsigned CFG_DCOFF_BIT = 2;
  localparam int unsigned CFG_MUX_LSB   = 0;
  localparam int unsigned MUX_W         = 2;
  localparam logic [1:0] MUX_PINS     = 2'h0;
  localparam logic [1:0] MUX_SHORT    = 2'h1;
  localparam logic [1:0] MUX_TEST_POS = 2'h2;
  localparam logic [1:0] MUX_TEST_NEG = 2'h3;
  localparam logic [WORD_W-1:0] GAIN_UNITY = 24'h800000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_BUSY = 2'b10
  } ccr_resp_state_t;
endpackage : ccr_pkg
`default_nettype wire

// File: ccr_cal_word.sv
// Assembly of one 24-bit calibration word from its high and low registers.
`timescale 1ns/10ps
`default_nettype none
module ccr_cal_word
  import ccr_pkg::*;
#(
  parameter logic [WORD_W-1:0] RST_VAL = '0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [REG_W-1:0]  hi_i,
  input  wire logic [LO_W-1:0]   lo_i,
  output logic      [WORD_W-1:0] word_o
);
  // ********************************************************
  // High register on top, low byte below.
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      word_o <= RST_VAL;
    end else begin
      word_o <= {hi_i, lo_i}; // [RULE_10]
    end
  end

  word_concat_a: assert property ( // [RULE_10]
    @(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> word_o == {$past(hi_i), $past(lo_i)})
    else $error("Calibration word does not match its registers.");
endmodule : ccr_cal_word
`default_nettype wire

// File: ccr_input_route.sv
// Decode of the channel input selector into one-hot route controls.
`timescale 1ns/10ps
`default_nettype none
module ccr_input_route
  import ccr_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [MUX_W-1:0] sel_i,
  output logic                  route_pins_o,
  output logic                  route_short_o,
  output logic                  route_test_pos_o,
  output logic                  route_test_neg_o
);
  // ********************************************************
  // Registered one-hot route.
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      route_pins_o     <= 1'b1;
      route_short_o    <= 1'b0;
      route_test_pos_o <= 1'b0;
      route_test_neg_o <= 1'b0;
    end else begin
      route_pins_o     <= 1'b0;
      route_short_o    <= 1'b0;
      route_test_pos_o <= 1'b0;
      route_test_neg_o <= 1'b0;
      case (sel_i) // [RULE_08]
        MUX_PINS:     route_pins_o     <= 1'b1;
        MUX_SHORT:    route_short_o    <= 1'b1;
        MUX_TEST_POS: route_test_pos_o <= 1'b1;
        MUX_TEST_NEG: route_test_neg_o <= 1'b1;
        default:      route_pins_o     <= 1'b1;
      endcase
    end
  end

  route_decode_a: assert property ( // [RULE_08]
    @(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> {route_test_neg_o, route_test_pos_o, route_short_o,
                        route_pins_o} == (4'h1 << $past(sel_i)))
    else $error("Input route does not follow the selector.");
endmodule : ccr_input_route
`default_nettype wire

// File: ccr_regs.sv
// Channel calibration and configuration registers behind an AXI4-Lite slave.
//
// Function
// RULE_01 - Channel one offset high at 0Fh holds offset bits 23:8, resets zero, RW.
// RULE_02 - Channel one offset low at 10h keeps bits 7:0 high; low byte reads zero.
// RULE_03 - Channel one gain high at 11h holds gain bits 23:8, resets to 8000h.
// RULE_04 - The gain word is unsigned, from zero to just below two.
// RULE_05 - Channel one gain low at 12h keeps bits 7:0 high, resets zero.
// RULE_06 - Channel two config at 13h: signed phase delay 15:6, bits 5:3 read zero.
// RULE_07 - Config bit 2 clear follows the global filter; set disables it here.
// RULE_08 - Selector: pins, shorted, positive test, negative test for 00 to 11.
// RULE_09 - Channel two offset high at 14h holds offset bits 23:8, resets zero.
// RULE_10 - Each word is the high register followed by the low register's upper byte.
// RULE_11 - After reset each gain word equals 800000h, a gain of one.
`timescale 1ns/10ps
`default_nettype none
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DCF_W  = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [STRB_W-1:0] s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic      [1:0]        s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic      [DATA_W-1:0] s_axi_rdata_o,
  output logic      [1:0]        s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic [DCF_W-1:0]  global_dc_filter_setting_i,
  output logic      [WORD_W-1:0] ch1_offset_word_o,
  output logic      [WORD_W-1:0] ch1_gain_word_o,
  output logic                   ch1_gain_unity_o,
  output logic                   ch1_gain_at_least_one_o,
  output logic      [REG_W-1:0]  ch2_offset_upper_bits_o,
  output logic      [PHASE_W-1:0] ch2_phase_delay_o,
  output logic                   ch2_dc_filter_off_o,
  output logic      [DCF_W-1:0]  ch2_dc_filter_setting_o,
  output logic                   ch2_route_pins_o,
  output logic                   ch2_route_short_o,
  output logic                   ch2_route_test_pos_o,
  output logic                   ch2_route_test_neg_o
);
  // ********************************************************
  // Elaboration checks.
  // ********************************************************
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8 to reach every register.");
  end
  if (DCF_W < 1) begin : g_bad_dcf
    $error("DCF_W must be at least 1.");
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ********************************************************
  // Address decode.
  // ********************************************************
  function automatic logic map_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a >> ADDR_LSB;
    map_hit = (a[ADDR_LSB-1:0] == '0)
           && (idx >= ADDR_W'(IDX_FIRST))
           && (idx <= ADDR_W'(IDX_LAST));
  endfunction : map_hit

  function automatic logic [SLOT_W-1:0] map_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a >> ADDR_LSB;
    map_slot = SLOT_W'(idx - ADDR_W'(IDX_FIRST));
  endfunction : map_slot

  // ********************************************************
  // Register storage.
  // ********************************************************
  logic [REG_W-1:0]  regs_r [NUM_REGS];
  logic              wr_fire;
  logic              wr_en;
  logic [SLOT_W-1:0] wr_slot;
  logic [REG_W-1:0]  wr_data;
  logic [REG_W-1:0]  wr_lane_mask;

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        regs_r[g] <= RESET_VALS[g]; // [RULE_01] [RULE_03] [RULE_05] [RULE_09]
      end else if (wr_en && (wr_slot == SLOT_W'(g))) begin
        regs_r[g] <= (regs_r[g] & ~(wr_lane_mask & WRITE_MASKS[g]))
                   | (wr_data & wr_lane_mask & WRITE_MASKS[g]); // [RULE_02] [RULE_06]
      end
    end
  end

  // ********************************************************
  // Write address and data channels.
  // ********************************************************
  ccr_resp_state_t   wst_r;
  ccr_resp_state_t   wst_nxt;
  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r;
  logic [STRB_W-1:0] w_strb_r;
  logic              aw_hs;
  logic              w_hs;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_wdata;
  logic [STRB_W-1:0] wr_strb;
  logic [1:0]        bresp_r;

  assign s_axi_awready_o = !aw_got_r && (wst_r == RS_IDLE);
  assign s_axi_wready_o  = !w_got_r && (wst_r == RS_IDLE);
  assign aw_hs           = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs            = s_axi_wvalid_i && s_axi_wready_o;
  assign wr_addr         = aw_got_r ? aw_addr_r : s_axi_awaddr_i;
  assign wr_wdata        = w_got_r ? w_data_r : s_axi_wdata_i;
  assign wr_strb         = w_got_r ? w_strb_r : s_axi_wstrb_i;
  assign wr_fire         = (aw_got_r || aw_hs) && (w_got_r || w_hs)
                        && (wst_r == RS_IDLE);
  assign wr_en           = wr_fire && map_hit(wr_addr);
  assign wr_slot         = map_slot(wr_addr);
  assign wr_data         = wr_wdata[REG_W-1:0];
  assign wr_lane_mask    = {{LO_W{wr_strb[1]}}, {LO_W{wr_strb[0]}}};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= '0;
    end else if (wr_fire) begin
      aw_got_r  <= 1'b0;
    end else if (aw_hs) begin
      aw_got_r  <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_got_r  <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (wr_fire) begin
      w_got_r  <= 1'b0;
    end else if (w_hs) begin
      w_got_r  <= 1'b1;
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
    end
  end

  // ********************************************************
  // Write response channel.
  // ********************************************************
  always_comb begin
    wst_nxt = wst_r;
    case (wst_r)
      RS_IDLE: begin
        if (wr_fire) begin
          wst_nxt = RS_BUSY;
        end
      end
      RS_BUSY: begin
        if (s_axi_bready_i) begin
          wst_nxt = RS_IDLE;
        end
      end
      default: wst_nxt = RS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wst_r   <= RS_IDLE;
      bresp_r <= RESP_OKAY;
    end else begin
      wst_r <= wst_nxt;
      if (wr_fire) begin
        bresp_r <= map_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_bvalid_o = (wst_r == RS_BUSY);
  assign s_axi_bresp_o  = bresp_r;

  // ********************************************************
  // Read channels.
  // ********************************************************
  ccr_resp_state_t   rst_r;
  ccr_resp_state_t   rst_nxt;
  logic              ar_hs;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0]        rresp_r;

  assign s_axi_arready_o = (rst_r == RS_IDLE);
  assign ar_hs           = s_axi_arvalid_i && s_axi_arready_o;

  always_comb begin
    rst_nxt = rst_r;
    case (rst_r)
      RS_IDLE: begin
        if (ar_hs) begin
          rst_nxt = RS_BUSY;
        end
      end
      RS_BUSY: begin
        if (s_axi_rready_i) begin
          rst_nxt = RS_IDLE;
        end
      end
      default: rst_nxt = RS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_r   <= RS_IDLE;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      rst_r <= rst_nxt;
      if (ar_hs && map_hit(s_axi_araddr_i)) begin
        rdata_r <= DATA_W'(regs_r[map_slot(s_axi_araddr_i)]);
        rresp_r <= RESP_OKAY;
      end else if (ar_hs) begin
        rdata_r <= '0;
        rresp_r <= RESP_SLVERR;
      end
    end
  end

  assign s_axi_rvalid_o = (rst_r == RS_BUSY);
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;

  // ********************************************************
  // Calibration words.
  // ********************************************************
  ccr_cal_word #(
    .RST_VAL (WORD_W'(0))
  ) u_ch1_offset (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .hi_i    (regs_r[SLOT_CH1_OFFSET_HIGH]),
    .lo_i    (regs_r[SLOT_CH1_OFFSET_LOW][LO_BYTE_LSB +: LO_W]),
    .word_o  (ch1_offset_word_o)
  );

  ccr_cal_word #(
    .RST_VAL (GAIN_UNITY)
  ) u_ch1_gain (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .hi_i    (regs_r[SLOT_CH1_GAIN_HIGH]),
    .lo_i    (regs_r[SLOT_CH1_GAIN_LOW][LO_BYTE_LSB +: LO_W]),
    .word_o  (ch1_gain_word_o)
  );

  // ********************************************************
  // Gain interpretation and channel two controls.
  // ********************************************************
  logic [WORD_W-1:0] gain_cat;

  assign gain_cat = {regs_r[SLOT_CH1_GAIN_HIGH],
                     regs_r[SLOT_CH1_GAIN_LOW][LO_BYTE_LSB +: LO_W]};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ch1_gain_unity_o        <= 1'b1; // [RULE_11]
      ch1_gain_at_least_one_o <= 1'b1;
    end else begin
      ch1_gain_unity_o        <= (gain_cat == GAIN_UNITY); // [RULE_11]
      ch1_gain_at_least_one_o <= (gain_cat >= GAIN_UNITY); // [RULE_04]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ch2_offset_upper_bits_o <= RST_ZERO;
      ch2_phase_delay_o       <= '0;
      ch2_dc_filter_off_o     <= 1'b0;
      ch2_dc_filter_setting_o <= '0;
    end else begin
      ch2_offset_upper_bits_o <= regs_r[SLOT_CH2_OFFSET_HIGH]; // [RULE_09]
      ch2_phase_delay_o       <= regs_r[SLOT_CH2_CONFIG][CFG_PHASE_LSB +: PHASE_W]; // [RULE_06]
      ch2_dc_filter_off_o     <= regs_r[SLOT_CH2_CONFIG][CFG_DCOFF_BIT];
      ch2_dc_filter_setting_o <= regs_r[SLOT_CH2_CONFIG][CFG_DCOFF_BIT]
                               ? '0 : global_dc_filter_setting_i; // [RULE_07]
    end
  end

  ccr_input_route u_ch2_route (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .sel_i            (regs_r[SLOT_CH2_CONFIG][CFG_MUX_LSB +: MUX_W]),
    .route_pins_o     (ch2_route_pins_o),
    .route_short_o    (ch2_route_short_o),
    .route_test_pos_o (ch2_route_test_pos_o),
    .route_test_neg_o (ch2_route_test_neg_o)
  );

  // ********************************************************
  // Checks.
  // ********************************************************
  offset_high_write_a: assert property ( // [RULE_01]
    wr_en && wr_slot == SLOT_W'(SLOT_CH1_OFFSET_HIGH) && (&wr_strb[1:0])
    |=> regs_r[SLOT_CH1_OFFSET_HIGH] == $past(wr_data))
    else $error("Offset high register did not take a full write.");

  offset_low_rsvd_a: assert property ( // [RULE_02]
    regs_r[SLOT_CH1_OFFSET_LOW][RSVD_LSB +: RSVD_W] == '0)
    else $error("Offset low reserved byte is not zero.");

  gain_reset_val_a: assert property ( // [RULE_03]
    $past(!rst_n_i) |-> regs_r[SLOT_CH1_GAIN_HIGH] == RST_GAIN_HIGH
                     && regs_r[SLOT_CH1_GAIN_LOW] == RST_ZERO)
    else $error("Gain registers left reset with wrong values.");

  gain_unsigned_a: assert property ( // [RULE_04]
    $past(rst_n_i) |-> ch1_gain_at_least_one_o == $past(gain_cat[WORD_W-1]))
    else $error("Gain word not treated as unsigned.");

  gain_low_rsvd_a: assert property ( // [RULE_05]
    regs_r[SLOT_CH1_GAIN_LOW][RSVD_LSB +: RSVD_W] == '0)
    else $error("Gain low reserved byte is not zero.");

  config_rsvd_a: assert property ( // [RULE_06]
    regs_r[SLOT_CH2_CONFIG][CFG_RSVD_LSB +: CFG_RSVD_W] == '0)
    else $error("Config reserved bits are not zero.");

  dc_filter_gate_a: assert property ( // [RULE_07]
    $past(rst_n_i) |-> ch2_dc_filter_setting_o ==
      ($past(regs_r[SLOT_CH2_CONFIG][CFG_DCOFF_BIT]) ? '0
                                                     : $past(global_dc_filter_setting_i)))
    else $error("Filter setting does not follow the disable bit.");

  ch2_offset_out_a: assert property ( // [RULE_09]
    wr_en && wr_slot == SLOT_W'(SLOT_CH2_OFFSET_HIGH) && (&wr_strb[1:0])
    |=> ##1 ch2_offset_upper_bits_o == $past(wr_data, 2))
    else $error("Channel two offset output did not follow a write.");

  gain_unity_rst_a: assert property ( // [RULE_11]
    $past(!rst_n_i) |-> ch1_gain_word_o == GAIN_UNITY && ch1_gain_unity_o)
    else $error("Gain word is not unity after reset.");

  write_resp_a: assert property (
    wr_fire |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
    else $error("Write response not raised one cycle after the write.");

  read_resp_a: assert property (
    ar_hs |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("Read response not raised one cycle after the request.");
endmodule : ccr_regs
`default_nettype wire

// File: ccr_host_model.sv
// Host model that drives the register bus of the calibration registers.
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model
  import ccr_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [7:0]        awaddr_o,
  output logic                   awvalid_o,
  input  wire logic              awready_i,
  output logic      [DATA_W-1:0] wdata_o,
  output logic      [STRB_W-1:0] wstrb_o,
  output logic                   wvalid_o,
  input  wire logic              wready_i,
  input  wire logic [1:0]        bresp_i,
  input  wire logic              bvalid_i,
  output logic                   bready_o,
  output logic      [7:0]        araddr_o,
  output logic                   arvalid_o,
  input  wire logic              arready_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic [1:0]        rresp_i,
  input  wire logic              rvalid_i,
  output logic                   rready_o,
  output logic                   timeout_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o, timeout_o} = '0;
  end
  // Released address and data payloads are inverted (the strobes stay set) so a stale value is never read as valid.
  task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d, output logic [1:0] rsp);
    logic pa, pw, pb, ta, tw, tb;
    int   n;
    @(posedge clk_i);
    {pa, pw, pb} = 3'h7;
    n = 0;
    rsp = 2'h1;
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while ((pa || pw || pb) && n < 64) begin
      @(negedge clk_i);
      ta = pa && awready_i;
      tw = pw && wready_i;
      tb = !pa && !pw && bvalid_i;
      if (tb) rsp = bresp_i;
      @(posedge clk_i);
      if (ta) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
        pw = 1'b0;
      end
      if (tb) begin
        bready_o <= 1'b0;
        pb = 1'b0;
      end
      n++;
    end
    if (pa || pw || pb) timeout_o <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [DATA_W-1:0] d, output logic [1:0] rsp);
    logic pa, pr, ta, tr;
    int   n;
    @(posedge clk_i);
    {pa, pr} = 2'h3;
    n = 0;
    d = '1;
    rsp = 2'h1;
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while ((pa || pr) && n < 64) begin
      @(negedge clk_i);
      ta = pa && arready_i;
      tr = !pa && rvalid_i;
      if (tr) begin
        d = rdata_i;
        rsp = rresp_i;
      end
      @(posedge clk_i);
      if (ta) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
        pa = 1'b0;
      end
      if (tr) begin
        rready_o <= 1'b0;
        pr = 1'b0;
      end
      n++;
    end
    if (pa || pr) timeout_o <= 1'b1;
  endtask : rd
endmodule : ccr_host_model
`default_nettype wire

// File: ccr_regs_tb.sv
// Self-checking testbench of the calibration registers.
`timescale 1ns/10ps
`default_nettype none
module ccr_regs_tb;
  import ccr_pkg::*;
  logic              clk_i, rst_n_i, to;
  logic [7:0]        awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [STRB_W-1:0] wstrb;
  logic [1:0]        bresp, rresp, r;
  logic [3:0]        dcf, dcf_out;
  logic [WORD_W-1:0] ofs_w, gain_w;
  logic [REG_W-1:0]  ofs2;
  logic [9:0]        phase;
  logic              unity, ge_one, dcoff, rp, rs, rtp, rtn;
  int                n_fail, n_compared;
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ccr_host_model host_i (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready), .timeout_o(to));
  ccr_regs ccr_regs_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .global_dc_filter_setting_i(dcf), .ch1_offset_word_o(ofs_w),
    .ch1_gain_word_o(gain_w), .ch1_gain_unity_o(unity), .ch1_gain_at_least_one_o(ge_one),
    .ch2_offset_upper_bits_o(ofs2), .ch2_phase_delay_o(phase), .ch2_dc_filter_off_o(dcoff),
    .ch2_dc_filter_setting_o(dcf_out), .ch2_route_pins_o(rp), .ch2_route_short_o(rs),
    .ch2_route_test_pos_o(rtp), .ch2_route_test_neg_o(rtn));
  function automatic logic [7:0] ad(input int i);
    return 8'((int'(IDX_FIRST) + i) * 4);
  endfunction : ad
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge to) begin
    n_fail++;
    complete_run();
  end
  initial begin
    rst_n_i = 1'b0;
    dcf = 4'h5;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      host_i.rd(ad(i), d, r);
      check(d, 32'(RESET_VALS[i]));
    end
    settle();
    check(gain_w, GAIN_UNITY);
    check({unity, ge_one, rp}, 3'h7);
    $display("test reset values done");
    for (int i = 0; i < NUM_REGS; i++) begin
      host_i.wr(ad(i), 32'hffffffff, r);
      check(r, RESP_OKAY);
      host_i.rd(ad(i), d, r);
      check(d, 32'(WRITE_MASKS[i]));
    end
    settle();
    check({ofs_w, ofs2}, 40'hffffffffff);
    check({gain_w, ge_one, unity}, 26'h3fffffe);
    check({phase, dcoff, dcf_out, rtn}, 16'hffe1);
    $display("test all ones done");
    host_i.wr(ad(0), 32'h00001234, r);
    host_i.wr(ad(1), 32'h0000abcd, r);
    host_i.wr(ad(2), 32'h00007fff, r);
    host_i.wr(ad(3), 32'h000000ff, r);
    settle();
    check(ofs_w, 24'h1234ab);
    check({gain_w, ge_one, unity}, 26'h1fffc00);
    $display("test word assembly done");
    for (int s = 0; s < 4; s++) begin
      host_i.wr(ad(4), 32'h8000 | 32'(s), r);
      settle();
      check({rtn, rtp, rs, rp}, 4'h1 << s);
      check({phase, dcoff, dcf_out}, {10'h200, 1'b0, dcf});
      @(posedge clk_i);
      dcf <= dcf + 4'h3;
    end
    $display("test input select done");
    foreach (d[i]) if (i < 3) begin
      host_i.wr(i == 0 ? 8'h38 : (i == 1 ? 8'h54 : 8'h3d), 32'h0000ffff, r);
      check(r, RESP_SLVERR);
      host_i.rd(i == 0 ? 8'h38 : (i == 1 ? 8'h54 : 8'h3d), d, r);
      check({d, r}, {32'h0, RESP_SLVERR});
    end
    host_i.rd(ad(0), d, r);
    check({d, r}, {32'h1234, RESP_OKAY});
    $display("test unmapped access done");
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host_i.rd(ad(2), d, r);
    check(d, 32'(RST_GAIN_HIGH));
    settle();
    check({gain_w, unity, ofs_w}, {GAIN_UNITY, 1'b1, 24'h0});
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : ccr_regs_tb
`default_nettype wire
